// File: logic/bank_map.svh
/*
 Register offsets, field positions, reset values and sizes of one FIFO bank.
 Assumes inclusion by bare name before the package and the modules.
*/
`ifndef BANK_MAP_SVH
`define BANK_MAP_SVH
`define DATA_W 18
`define PIN_W 25
`define PTR_W 8
`define CNT_W 9
`define LVL_W 10
`define BANK_DEPTH 9'h100
`define STD_DEPTH 10'h100
`define FIRST_WORD_PASS_MODE_DEPTH 10'h101
`define LAST_LOC 8'hFF
`define BUF_DEPTH 8
`define BUF_LVL_W 4
`define REG_EMPTY_OFS 12'h000
`define REG_FULL_OFS 12'h004
`define REG_STATUS 12'h008
`define REG_LEVEL 12'h00C
`define EMPTY_OFS_RST 9'h007
`define FULL_OFS_RST 9'h007
`define ST_EMPTY_PIN 0
`define ST_FULL_PIN 1
`define ST_AE 2
`define ST_AF 3
`define ST_FIRST_WORD_PASS_MODE 4
`define ST_DBL 5
`define ST_SYNC 6
`define ST_CHAIN 7
`endif

// File: logic/bank_pkg.sv
/*
 Types shared by the bank: data word, decoded strap mode, bank state.
 Assumes bank_map.svh is available on the include path.
*/
`include "bank_map.svh"
package bank_pkg;
   typedef logic [`DATA_W-1:0] word_t;
   typedef struct packed {
      logic first_word_pass_mode;
      logic dbl;
      logic sync_part;
      logic chain;
   } mode_t;
   typedef struct packed {
      mode_t mode;
      logic [255:0][`DATA_W-1:0] mem;
      logic [`PTR_W-1:0] wp;
      logic [`PTR_W-1:0] rp;
      logic [`CNT_W-1:0] cnt;
      word_t dout;
      logic outv;
      logic avail_stage;
      logic avail;
      logic space_stage;
      logic space;
      logic ae;
      logic af;
      logic chain_out;
      logic [`CNT_W-1:0] eofs;
      logic [`CNT_W-1:0] fofs;
      logic [31:0] prdata;
      logic pslverr;
   } bank_state_t;
endpackage : bank_pkg

// File: logic/stream_if.sv
/*
 Valid/ready word stream between the bank and its input buffer.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface stream_if #(parameter int W = 18) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : stream_if

// File: logic/sync_edge.sv
/*
 Two-flop synchroniser for pin inputs with rising-edge detect.
 Assumes inputs are asynchronous to clk; rise compares the second and third stages.
*/
`timescale 1ns/10ps
module sync_edge #(parameter int W = 1) (
   input logic clk,
   input logic rst_b,
   input logic ce,
   input logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);
   import bank_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sync_state_t;
   sync_state_t st, next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // The first two stages run through reset so the straps reach the decode in time
      if (!rst_b) begin
         next_st.s3 = '1;
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         st <= next_st;
      end
   end

   assign q = st.s2;
   assign rise = st.s2 & ~st.s3;
endmodule : sync_edge

// File: logic/word_fifo.sv
/*
 Small flop-based FIFO with valid/ready on both sides and a fill level.
 Assumes one clock; DEPTH need not be a power of two.
*/
`timescale 1ns/10ps
module word_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH),
   parameter int LW = $clog2(DEPTH + 1)
) (
   input logic clk,
   input logic rst_b,
   input logic ce,
   stream_if.snk wr,
   stream_if.src rd,
   output logic [LW-1:0] level
);
   import bank_pkg::*;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [LW-1:0] lvl;
   } fifo_state_t;
   fifo_state_t st, next_st;
   logic push;
   logic pull;

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : wrap

   assign wr.ready = (st.lvl != LW'(DEPTH));
   assign rd.valid = (st.lvl != '0);
   assign rd.data = st.mem[st.rp];
   assign level = st.lvl;
   assign push = wr.valid & wr.ready;
   assign pull = rd.valid & rd.ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = wr.data;
         next_st.wp = wrap(st.wp);
      end
      if (pull) begin
         next_st.rp = wrap(st.rp);
      end
      next_st.lvl = LW'(st.lvl + LW'(push) - LW'(pull));
      if (!rst_b) begin
         next_st = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         st <= next_st;
      end
   end
endmodule : word_fifo

// File: logic/fifo_flag_bank.sv
/*
 One bank of a dual-clock 18-bit FIFO: storage, strap mode decode,
 empty/full and ready flags, almost-empty/full flags, APB offsets/status.
 Assumes write and read clocks arrive as pins slower than a quarter of
 CLK_SYS, so they are sampled rather than used as clocks.
*/
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "bank_map.svh"
module fifo_flag_bank (
   input logic CLK_SYS,
   input logic RST_B,
   input logic CE,
   input logic PSEL,
   input logic PENABLE,
   input logic PWRITE,
   input logic [11:0] PADDR,
   input logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input logic WRITE_CLK,
   input logic READ_CLK,
   input logic WRITE_EN_B,
   input logic READ_EN_B,
   input bank_pkg::word_t DATA_IN,
   input logic FIRST_LOAD_STRAP,
   input logic READ_CHAIN_IN,
   input logic WRITE_CHAIN_IN,
   output bank_pkg::word_t DATA_OUT,
   output logic EMPTY_FLAG_N,
   output logic FULL_FLAG_N,
   output logic ALMOST_EMPTY_FLAG,
   output logic ALMOST_FULL_FLAG,
   output logic READ_CHAIN_OUT
);
   import bank_pkg::*;
   bank_state_t st, next_st;
   logic [`PIN_W-1:0] pin_raw;
   logic [`PIN_W-1:0] pin_q;
   logic [`PIN_W-1:0] pin_rise;
   logic wr_edge;
   logic rd_edge;
   logic wen_b;
   logic ren_b;
   word_t din;
   logic [2:0] strap;
   logic [`BUF_LVL_W-1:0] buf_lvl;
   logic [`LVL_W-1:0] lvl;
   logic [`LVL_W-1:0] nlvl;
   logic [`LVL_W-1:0] dep;
   logic [`LVL_W-1:0] ae_thr;
   logic [`LVL_W-1:0] af_thr;
   logic wr_req;
   logic rd_req;
   logic pop;
   logic load;
   logic take;
   logic drain;
   logic ae_hi;
   logic af_hi;
   logic navail;
   logic nspace;
   logic setup;
   logic wr_acc;
   stream_if #(.W(`DATA_W)) in_s ();
   stream_if #(.W(`DATA_W)) out_s ();

   function automatic mode_t decode_mode(input logic [2:0] s);
      mode_t m;
      m.first_word_pass_mode = (s == 3'h1) || (s == 3'h5);
      m.dbl = (s == 3'h2) || (s == 3'h5) || (s == 3'h6);
      m.sync_part = (s == 3'h4) || (s == 3'h5) || (s == 3'h6);
      m.chain = (s == 3'h3) || (s == 3'h7);
      return m;
   endfunction : decode_mode

   function automatic logic [`PTR_W-1:0] step(input logic [`PTR_W-1:0] p);
      return `PTR_W'(p + 1'b1);
   endfunction : step

   // Clock pins are sampled: bank clocks must be well below CLK_SYS
   assign pin_raw = {DATA_IN, FIRST_LOAD_STRAP, READ_CHAIN_IN, WRITE_CHAIN_IN,
                     READ_EN_B, WRITE_EN_B, READ_CLK, WRITE_CLK};

   sync_edge #(.W(`PIN_W)) pins (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .ce(CE),
      .d(pin_raw),
      .q(pin_q),
      .rise(pin_rise)
   );

   assign wr_edge = pin_rise[0];
   assign rd_edge = pin_rise[1];
   assign wen_b = pin_q[2];
   assign ren_b = pin_q[3];
   assign strap = pin_q[6:4];
   assign din = pin_q[24:7];

   // Input buffer holds writes while the array count stands at BANK_DEPTH
   word_fifo #(.WIDTH(`DATA_W), .DEPTH(`BUF_DEPTH)) in_buf (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .ce(CE),
      .wr(in_s),
      .rd(out_s),
      .level(buf_lvl)
   );

   assign dep = st.mode.first_word_pass_mode ? `FIRST_WORD_PASS_MODE_DEPTH : `STD_DEPTH;
   assign lvl = `LVL_W'(st.cnt) + `LVL_W'(buf_lvl) + `LVL_W'(st.outv);
   assign ae_thr = `LVL_W'(st.eofs) + `LVL_W'(st.mode.first_word_pass_mode);
   assign af_thr = `LVL_W'(dep - `LVL_W'(st.fofs));

   assign wr_req = wr_edge & ~wen_b & st.space & in_s.ready;
   assign in_s.valid = wr_req;
   assign in_s.data = din;
   assign out_s.ready = (st.cnt < `BANK_DEPTH);
   assign drain = out_s.valid & out_s.ready;

   assign rd_req = rd_edge & ~ren_b & st.avail & (st.cnt != '0) & ~st.mode.first_word_pass_mode;
   assign pop = rd_edge & ~ren_b & st.avail & st.outv & st.mode.first_word_pass_mode;
   assign load = st.mode.first_word_pass_mode & rd_edge & (~st.outv | pop) & (st.cnt != '0);
   assign take = rd_req | load;

   assign nlvl = `LVL_W'(lvl + `LVL_W'(wr_req) - `LVL_W'(rd_req | pop));
   assign ae_hi = (nlvl > ae_thr);
   assign af_hi = (nlvl < af_thr);
   assign nspace = (nlvl < dep);

   assign setup = PSEL & ~PENABLE;
   assign wr_acc = PSEL & PENABLE & PWRITE;

   always_comb begin
      next_st = st;
      next_st.chain_out = 1'b0;
      if (drain) begin
         next_st.mem[st.wp] = out_s.data;
         next_st.wp = step(st.wp);
      end
      if (take) begin
         next_st.dout = st.mem[st.rp];
         next_st.rp = step(st.rp);
         next_st.chain_out = st.mode.chain & (st.rp == `LAST_LOC);
      end
      next_st.cnt = `CNT_W'(st.cnt + `CNT_W'(drain) - `CNT_W'(take));
      if (load) begin
         next_st.outv = 1'b1;
      end else if (pop) begin
         next_st.outv = 1'b0;
      end
      navail = st.mode.first_word_pass_mode ? next_st.outv : (next_st.cnt != '0);
      // Flags assert at once, but in double-buffer mode deassertion waits one more edge
      if (rd_edge) begin
         next_st.avail_stage = navail;
         next_st.avail = navail & (st.avail_stage | ~st.mode.dbl);
      end
      if (wr_edge) begin
         next_st.space_stage = nspace;
         next_st.space = nspace & (st.space_stage | ~st.mode.dbl);
      end
      if (st.mode.sync_part) begin
         if (rd_edge) begin
            next_st.ae = ae_hi;
         end
         if (wr_edge) begin
            next_st.af = af_hi;
         end
      end else begin
         // Unsynchronised style: set on one side, cleared from the other
         if (rd_edge && !ae_hi) begin
            next_st.ae = 1'b0;
         end
         if (wr_edge && ae_hi) begin
            next_st.ae = 1'b1;
         end
         if (wr_edge && !af_hi) begin
            next_st.af = 1'b0;
         end
         if (rd_edge && af_hi) begin
            next_st.af = 1'b1;
         end
      end
      if (setup) begin
         next_st.pslverr = 1'b0;
         unique case (PADDR)
            `REG_EMPTY_OFS: next_st.prdata = 32'(st.eofs);
            `REG_FULL_OFS: next_st.prdata = 32'(st.fofs);
            `REG_STATUS: next_st.prdata = 32'({st.mode.chain, st.mode.sync_part,
                                              st.mode.dbl, st.mode.first_word_pass_mode, st.af,
                                              st.ae, FULL_FLAG_N, EMPTY_FLAG_N});
            `REG_LEVEL: next_st.prdata = 32'(lvl);
            default: begin
               next_st.prdata = '0;
               next_st.pslverr = 1'b1;
            end
         endcase
      end
      if (wr_acc && PADDR == `REG_EMPTY_OFS) begin
         next_st.eofs = PWDATA[`CNT_W-1:0];
      end
      if (wr_acc && PADDR == `REG_FULL_OFS) begin
         next_st.fofs = PWDATA[`CNT_W-1:0];
      end
      if (!RST_B) begin
         next_st = '0;
         next_st.mode = decode_mode(strap);
         next_st.space = 1'b1;
         next_st.space_stage = 1'b1;
         next_st.af = 1'b1;
         next_st.eofs = `EMPTY_OFS_RST;
         next_st.fofs = `FULL_OFS_RST;
      end
   end

   // Whole bank state is local, so two instances share nothing
   always_ff @(posedge CLK_SYS) begin
      if (CE) begin
         st <= next_st;
      end
   end

   assign PREADY = 1'b1;
   assign PRDATA = st.prdata;
   assign PSLVERR = st.pslverr;
   assign DATA_OUT = st.dout;
   assign EMPTY_FLAG_N = st.mode.first_word_pass_mode ? ~st.avail : st.avail;
   assign FULL_FLAG_N = st.mode.first_word_pass_mode ? ~st.space : st.space;
   assign ALMOST_EMPTY_FLAG = st.ae;
   assign ALMOST_FULL_FLAG = st.af;
   assign READ_CHAIN_OUT = st.chain_out;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_B);

   AST_AE_READ_ONLY: assert property (
      st.mode.sync_part && $changed(st.ae) |-> $past(rd_edge && CE))
      else $error("almost-empty moved without a read edge");
   AST_AF_WRITE_ONLY: assert property (
      st.mode.sync_part && $changed(st.af) |-> $past(wr_edge && CE))
      else $error("almost-full moved without a write edge");
   AST_AE_RISE: assert property (
      st.mode.sync_part && rd_edge && CE && ae_hi |=> st.ae)
      else $error("almost-empty missed its read edge");
   AST_AF_RISE: assert property (
      st.mode.sync_part && wr_edge && CE && af_hi |=> st.af)
      else $error("almost-full missed its write edge");
   AST_FULL_DOUBLE: assert property (
      st.mode.dbl && !st.mode.first_word_pass_mode && $rose(st.space) |-> $past(st.space_stage))
      else $error("full flag cleared without the buffer stage");
   AST_EMPTY_DOUBLE: assert property (
      st.mode.dbl && !st.mode.first_word_pass_mode && $rose(st.avail) |-> $past(st.avail_stage))
      else $error("empty flag cleared without the buffer stage");
   AST_READY_TWO_EDGES: assert property (
      st.mode.dbl && st.mode.first_word_pass_mode && $rose(st.avail) |-> $past(st.outv))
      else $error("output-ready asserted on the loading edge");
   AST_INPUT_READY: assert property (
      st.mode.first_word_pass_mode && wr_edge && CE && nspace && st.space_stage |=> st.space)
      else $error("input-ready late");
   AST_FIRST_WORD_PASS_MODE_DEPTH: assert property (
      st.mode.first_word_pass_mode |-> lvl <= `FIRST_WORD_PASS_MODE_DEPTH)
      else $error("pass-through level above 257");
   AST_STD_DEPTH: assert property (
      !st.mode.first_word_pass_mode |-> lvl <= `STD_DEPTH)
      else $error("standard level above 256");
   AST_FIRST_WORD_PASS_MODE_SINGLE: assert property (
      st.mode.first_word_pass_mode && !st.mode.dbl && load && CE |=> st.avail)
      else $error("output-ready missed the loading edge");
   AST_STANDALONE: assert property (
      st.chain_out |-> st.mode.chain)
      else $error("chain pulse in stand-alone mode");
   AST_CHAIN_PULSE: assert property (
      st.chain_out |-> $past(take && CE) && $past(st.rp) == `LAST_LOC)
      else $error("chain pulse without last-location read");
   AST_AE_STD_LEVEL: assert property (
      st.mode.sync_part && !st.mode.first_word_pass_mode && $past(rd_edge && CE)
      |-> st.ae == ($past(nlvl) > $past(`LVL_W'(st.eofs))))
      else $error("standard almost-empty level wrong");
   AST_AE_FIRST_WORD_PASS_MODE_LEVEL: assert property (
      st.mode.sync_part && st.mode.first_word_pass_mode && $past(rd_edge && CE)
      |-> st.ae == ($past(nlvl) > $past(`LVL_W'(st.eofs)) + 10'h001))
      else $error("pass-through almost-empty level wrong");
   // Flags set on the event edge; only the clearing waits for the stage
   AST_EMPTY_AT_ONCE: assert property (
      rd_edge && CE && !navail |=> !st.avail)
      else $error("empty flag late");
   AST_FULL_AT_ONCE: assert property (
      wr_edge && CE && !nspace |=> !st.space)
      else $error("full flag late");
   AST_EMPTY_WAIT: assert property (
      st.mode.dbl && rd_edge && CE && !st.avail_stage |=> !st.avail)
      else $error("empty flag cleared a stage early");
   AST_FULL_WAIT: assert property (
      st.mode.dbl && wr_edge && CE && !st.space_stage |=> !st.space)
      else $error("full flag cleared a stage early");
   AST_CHAIN_SINGLE: assert property (
      st.chain_out |=> !st.chain_out)
      else $error("chain pulse longer than a cycle");
   AST_STRAP_DECODE: assert property (
      $rose(RST_B) && $past(CE) |-> st.mode == $past(decode_mode(strap)))
      else $error("mode differs from the straps held at reset");
   AST_POP_RELOAD: assert property (
      pop && load && CE |=> st.outv && st.dout == $past(st.mem[st.rp]))
      else $error("read did not reload the output register");
   AST_LOAD_SHOWS: assert property (
      load && CE |=> st.outv)
      else $error("loaded word not held");
   // Frozen enable must hold the count, both almost flags and the output word, even mid-transfer
   AST_CE_HOLD: assert property (
      !CE |=> $stable(st.cnt) && $stable(st.ae) && $stable(st.af) && $stable(st.dout))
      else $error("state moved with the enable low");
   AST_UNMAPPED: assert property (
      setup && CE && !(PADDR inside {`REG_EMPTY_OFS, `REG_FULL_OFS, `REG_STATUS, `REG_LEVEL})
      |=> PSLVERR && PRDATA == 32'h0000_0000)
      else $error("unmapped address answered without error");
   AST_OFFSET_WRITE: assert property (
      wr_acc && CE && PADDR == `REG_EMPTY_OFS |=> st.eofs == $past(PWDATA[`CNT_W-1:0]))
      else $error("empty offset write lost");

   COV_FULL: cover property (!st.space && lvl == dep);
   COV_FIRST_WORD_PASS_MODE_POP: cover property (pop && load && CE);
   COV_CHAIN: cover property (st.chain_out);
   COV_SYNC_AE: cover property (st.mode.sync_part && $rose(st.ae));
   COV_DBL_CLEAR: cover property (st.mode.dbl && $rose(st.space));
endmodule : fifo_flag_bank

// File: tb/bank_pins_model.sv
/*
 Pin-side writer and reader of one bank: bank clocks, enables, write data.
 Assumes CLK_SYS runs at least four times the rate of the bank clocks.
*/
`timescale 1ns/10ps
module bank_pins_model (
   input logic clk_sys,
   output logic wr_clk,
   output logic rd_clk,
   output logic wr_en_b,
   output logic rd_en_b,
   output bank_pkg::word_t din
);
   import bank_pkg::*;
   initial begin
      wr_clk = 1'b0;
      rd_clk = 1'b0;
      wr_en_b = 1'b1;
      rd_en_b = 1'b1;
      din = 18'h0_0000;
   end
   // One bank clock edge; bank clocks stand still between calls
   // Depth asked of one bank stays within its array
   task automatic pin_edge(input logic wr, input logic en_b, input word_t d);
      @(posedge clk_sys);
      if (wr) begin
         wr_en_b <= en_b;
         din <= d;
      end else begin
         rd_en_b <= en_b;
      end
      repeat (2) @(posedge clk_sys);
      wr_clk <= wr;
      rd_clk <= !wr;
      // Held past the two-flop sync so the edge sees stable qualifiers
      repeat (4) @(posedge clk_sys);
      wr_clk <= 1'b0;
      rd_clk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // Released lines show the inverse, not the last value
      wr_en_b <= 1'b1;
      rd_en_b <= 1'b1;
      din <= ~din;
   endtask : pin_edge
endmodule : bank_pins_model

// File: tb/fifo_flag_bank_bench.sv
/*
 Self-checking bench for one bank: strap decode table, fill in five strap modes
 with drain in the three standard ones, flag latencies, synchronous partial flags and the APB map.
 Assumes the pin model drives bank clocks; offsets reset to 7.
*/
`timescale 1ns/10ps
`include "bank_map.svh"
module fifo_flag_bank_bench;
   import bank_pkg::*;
   typedef struct {
      logic [2:0] strap;
      logic [31:0] status;
      logic [31:0] mask;
   } row_t;
   logic clk_sys;
   logic rst_b;
   logic ce;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wr_clk;
   logic rd_clk;
   logic wr_en_b;
   logic rd_en_b;
   logic [2:0] strap;
   word_t din;
   word_t dout;
   logic empty_flag_n;
   logic full_flag_n;
   logic almost_empty_flag;
   logic almost_full_flag;
   logic chain_out;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int samples_checked = 0;
   int chain_pulses = 0;
   // Double-buffer bit of code 5 left open, so masked
   row_t rows[8] = '{
      '{3'b000, 32'h0000_000A, 32'hFFFF_FFFF}, '{3'b001, 32'h0000_0019, 32'hFFFF_FFFF},
      '{3'b010, 32'h0000_002A, 32'hFFFF_FFFF}, '{3'b011, 32'h0000_008A, 32'hFFFF_FFFF},
      '{3'b100, 32'h0000_004A, 32'hFFFF_FFFF}, '{3'b101, 32'h0000_0059, 32'hFFFF_FFDF},
      '{3'b110, 32'h0000_006A, 32'hFFFF_FFFF}, '{3'b111, 32'h0000_008A, 32'hFFFF_FFFF}};
   logic [2:0] fill_modes[5] = '{3'b000, 3'b011, 3'b010, 3'b001, 3'b101};

   fifo_flag_bank dut_u (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .WRITE_CLK(wr_clk), .READ_CLK(rd_clk), .WRITE_EN_B(wr_en_b),
      .READ_EN_B(rd_en_b), .DATA_IN(din), .FIRST_LOAD_STRAP(strap[2]),
      .READ_CHAIN_IN(strap[1]), .WRITE_CHAIN_IN(strap[0]), .DATA_OUT(dout),
      .EMPTY_FLAG_N(empty_flag_n), .FULL_FLAG_N(full_flag_n),
      .ALMOST_EMPTY_FLAG(almost_empty_flag), .ALMOST_FULL_FLAG(almost_full_flag),
      .READ_CHAIN_OUT(chain_out));
   bank_pins_model model_u (.clk_sys(clk_sys), .wr_clk(wr_clk), .rd_clk(rd_clk),
      .wr_en_b(wr_en_b), .rd_en_b(rd_en_b), .din(din));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (chain_out === 1'b1) chain_pulses <= chain_pulses + 1;
   end

   function automatic word_t pat(input int i);
      return word_t'(i) ^ 18'h2_A5A5;
   endfunction : pat
   task automatic final_report;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         final_report();
      end
   endtask : apb
   task automatic do_reset(input logic [2:0] s);
      @(posedge clk_sys);
      strap <= s;
      rst_b <= 1'b0;
      // Straps pass two sync flops before decode
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
   endtask : do_reset
   task automatic fill_drain(input logic [2:0] s);
      bit fw;
      bit sy;
      bit dbl;
      int d;
      int h;
      fw = (s == 3'b001 || s == 3'b101);
      sy = s[2] && (s != 3'b111);
      dbl = (s == 3'b010 || s == 3'b110);
      d = fw ? 257 : 256;
      do_reset(s);
      chain_pulses = 0;
      for (int i = 1; i <= d + 1; i++) begin
         model_u.pin_edge(1'b1, 1'b0, pat(i));
         if (i == 1 && fw) begin
            model_u.pin_edge(1'b0, 1'b1, pat(0));
            if (s == 3'b001) check("ready single", 0, empty_flag_n);
            model_u.pin_edge(1'b0, 1'b1, pat(0));
            check("ready", 0, empty_flag_n);
            check("first word", pat(1), dout);
         end
         h = (i > d) ? d : i;
         if (!sy) begin
            check("almost empty", h > 7 + fw, almost_empty_flag);
            check("almost full", h < d - 7, almost_full_flag);
         end
      end
      apb(1'b0, `REG_LEVEL, 32'h0000_0000);
      check("level", d, rd);
      check("full", fw, full_flag_n);
      if (fw) begin
         model_u.pin_edge(1'b0, 1'b0, pat(0));
         check("next word", pat(2), dout);
         model_u.pin_edge(1'b1, 1'b1, pat(0));
         model_u.pin_edge(1'b1, 1'b1, pat(0));
         check("input ready", 0, full_flag_n);
      end else begin
         model_u.pin_edge(1'b0, 1'b1, pat(0));
         check("empty first edge", !dbl, empty_flag_n);
         model_u.pin_edge(1'b0, 1'b1, pat(0));
         check("empty second edge", 1, empty_flag_n);
         for (int i = 1; i <= 256; i++) begin
            model_u.pin_edge(1'b0, 1'b0, pat(0));
            check("data out", pat(i), dout);
            if (i == 1) begin
               model_u.pin_edge(1'b1, 1'b1, pat(0));
               check("full first edge", !dbl, full_flag_n);
               model_u.pin_edge(1'b1, 1'b1, pat(0));
               check("full second edge", 1, full_flag_n);
            end
         end
         model_u.pin_edge(1'b0, 1'b1, pat(0));
         model_u.pin_edge(1'b0, 1'b1, pat(0));
         check("empty at end", 0, empty_flag_n);
         check("chain pulses", s == 3'b011, chain_pulses);
      end
   endtask : fill_drain

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      strap = 3'b000;
      for (int k = 0; k < 8; k++) begin
         do_reset(rows[k].strap);
         apb(1'b0, `REG_STATUS, 32'h0000_0000);
         check("status", rows[k].status & rows[k].mask, rd & rows[k].mask);
         check("pins", rows[k].status[3:0], {almost_full_flag, almost_empty_flag,
            full_flag_n, empty_flag_n});
         apb(1'b0, `REG_EMPTY_OFS, 32'h0000_0000);
         check("empty offset", 7, rd);
         apb(1'b0, `REG_FULL_OFS, 32'h0000_0000);
         check("full offset", 7, rd);
      end
      foreach (fill_modes[k]) fill_drain(fill_modes[k]);
      // Synchronous partial flags: threshold of full moved to six words
      do_reset(3'b100);
      apb(1'b1, `REG_FULL_OFS, 32'h0000_00FA);
      for (int i = 1; i <= 8; i++) model_u.pin_edge(1'b1, 1'b0, pat(i));
      check("ae without read edge", 0, almost_empty_flag);
      check("af on write edges", 0, almost_full_flag);
      model_u.pin_edge(1'b0, 1'b1, pat(0));
      model_u.pin_edge(1'b0, 1'b1, pat(0));
      check("ae after read edges", 1, almost_empty_flag);
      for (int i = 0; i < 4; i++) model_u.pin_edge(1'b0, i == 3, pat(0));
      check("af without write edge", 0, almost_full_flag);
      check("ae after reads", 0, almost_empty_flag);
      model_u.pin_edge(1'b1, 1'b1, pat(0));
      model_u.pin_edge(1'b1, 1'b1, pat(0));
      check("af after write edges", 1, almost_full_flag);
      // Enable low: a write edge in that time is lost, level stays at five
      @(posedge clk_sys);
      ce <= 1'b0;
      model_u.pin_edge(1'b1, 1'b0, pat(9));
      ce <= 1'b1;
      check("frozen write", 1, almost_full_flag);
      apb(1'b1, `REG_EMPTY_OFS, 32'hFFFF_FFFF);
      apb(1'b0, `REG_EMPTY_OFS, 32'h0000_0000);
      check("offset field", 32'h0000_01FF, rd);
      apb(1'b1, `REG_STATUS, 32'h0000_0000);
      apb(1'b0, `REG_STATUS, 32'h0000_0000);
      check("status mode", 32'h0000_0040, rd & 32'h0000_00F0);
      apb(1'b0, `REG_LEVEL, 32'h0000_0000);
      check("level err", 0, err);
      check("level", 5, rd);
      apb(1'b0, 12'h010, 32'h0000_0000);
      check("unmapped err", 1, err);
      check("unmapped data", 0, rd);
      final_report();
   end
endmodule : fifo_flag_bank_bench
